// >>> sim/amr_checker.sv
`timescale 1ns/100ps
module amr_checker
  import amr_pkg::*;
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Link signals
  input wire logic       req,
  input wire logic [7:0] opcode,
  input wire logic [7:0] arg,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       mode_4b
);
  // Request taken: offered while no answer stands
  wire take = req && !ack;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ack_answer_a: assert property (take |=> ack) else $error("ack late");
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
  req_hold_a: assert property (take |=> req && $stable(opcode) && $stable(arg))
    else $error("request not held");
  enter_mode_a: assert property ($rose(mode_4b) |-> $past(take && opcode == AMR_CMD_EN4B))
    else $error("mode entered without B7h");
  leave_mode_a: assert property ($fell(mode_4b) |-> $past(take && opcode == AMR_CMD_RST))
    else $error("mode left without reset");
  byte_lo_a: assert property (take && opcode == AMR_CMD_RDPARAM && arg == 8'h3C ##1 ack
    |-> rdata == 8'hF0) else $error("byte 3C wrong");
  byte_one_a: assert property (take && opcode == AMR_CMD_RDPARAM && arg == 8'h3D ##1 ack
    |-> rdata == 8'h30) else $error("byte 3D wrong");
  byte_two_a: assert property (take && opcode == AMR_CMD_RDPARAM && arg == 8'h3E ##1 ack
    |-> rdata == 8'hF8) else $error("byte 3E wrong");
  byte_hi_a: assert property (take && opcode == AMR_CMD_RDPARAM && arg == 8'h3F ##1 ack
    |-> rdata == 8'hA1) else $error("byte 3F wrong");
  support_byte_a: assert property (take && opcode == AMR_CMD_RDPARAM && arg == 8'h40 ##1 ack
    |-> rdata == 8'h6B) else $error("byte 40 wrong");
endmodule : amr_checker

// >>> sim/test_addr_mode_reset_param_table.sv
`timescale 1ns/100ps
module test_addr_mode_reset_param_table;
  import amr_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic        aclk = 1'b0, aresetn = 1'b0, xip_active = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  op_width = AMR_W1, cw = AMR_W1, rsp;
  wire         awready, wready, bvalid, arready, rvalid, wren_out;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   sr1_out;
  int          errors = 0, total_checks = 0;
  amr_link_if amr_link_if_i ();
  amr_device amr_device_i (.aclk(aclk), .aresetn(aresetn), .link(amr_link_if_i), .op_width(op_width),
    .xip_active(xip_active), .sr1_out(sr1_out), .wren_out(wren_out));
  amr_host amr_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(amr_link_if_i));
  amr_checker amr_checker_i (.aclk(aclk), .aresetn(aresetn), .req(amr_link_if_i.req),
    .opcode(amr_link_if_i.opcode), .arg(amr_link_if_i.arg), .ack(amr_link_if_i.ack),
    .rdata(amr_link_if_i.rdata), .mode_4b(amr_link_if_i.mode_4b));
  // 20 MHz clock
  always #25 aclk = ~aclk;
  // ----------------
  // Bus tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Each channel held until its ready is seen at a rising edge; answer taken at that edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  // One instruction, waited on until the controller is idle again
  task automatic cmd(input logic [7:0] op, input logic [7:0] a = 8'h00, input logic dw = 1'b0);
    axw(AMR_REG_CTRL, {29'h0, dw, cw});
    axw(AMR_REG_CMD, {16'h0, a, op});
    do axr(AMR_REG_STAT); while (rd[0] !== 1'b0);
  endtask : cmd
  task automatic st(input logic exp);
    axr(AMR_REG_STAT);
    chk(rd[1], exp);
  endtask : st
  task automatic pair;
    cmd(AMR_CMD_RST_EN);
    cmd(AMR_CMD_RST);
  endtask : pair
  // ----------------
  // Scenarios
  // ----------------
  // Dword walk, with a second command refused while the walk is busy
  task automatic t_param;
    axw(AMR_REG_CTRL, {29'h0, 1'b1, cw});
    axw(AMR_REG_CMD, {16'h0, AMR_OFS_DW16_B0, AMR_CMD_RDPARAM});
    chk(rsp, AMR_RESP_OKAY);
    axw(AMR_REG_CMD, {16'h0, AMR_OFS_DW16_B0, AMR_CMD_RDPARAM});
    chk(rsp, AMR_RESP_SLVERR);
    do axr(AMR_REG_STAT); while (rd[0] !== 1'b0);
    axr(AMR_REG_RDATA);
    chk(rd, 32'hA1F830F0);
    cmd(AMR_CMD_RDPARAM, 8'h40);
    axr(AMR_REG_RDATA);
    chk(rd[7:0], 8'h6B);
    axr(4'h2);
    chk(rsp, AMR_RESP_SLVERR);
  endtask : t_param
  task automatic t_order;
    cmd(AMR_CMD_EN4B);
    st(1'b1);
    cmd(AMR_CMD_RST);
    st(1'b1);
    cmd(AMR_CMD_RST_EN);
    cmd(AMR_CMD_WREN);
    cmd(AMR_CMD_RST);
    st(1'b1);
    pair;
    st(1'b0);
  endtask : t_order
  // Each width: pair at a wrong width ignored, at the right one obeyed
  task automatic t_width;
    logic [1:0] ws [3] = '{AMR_W1, AMR_W2, AMR_W4};
    for (int i = 0; i < 3; i++) begin
      op_width <= ws[i];
      cw = ws[i];
      cmd(AMR_CMD_EN4B);
      cw = ws[(i + 1) % 3];
      pair;
      st(1'b1);
      cw = ws[i];
      pair;
      st(1'b0);
    end
    op_width <= AMR_W1;
    cw = AMR_W1;
  endtask : t_width
  task automatic t_sr1;
    cmd(AMR_CMD_WRSR1, 8'hA5);
    chk(sr1_out, 8'h00);
    cmd(AMR_CMD_WREN);
    chk(wren_out, 1'b1);
    cmd(AMR_CMD_WRSR1, 8'hA5);
    chk(sr1_out, 8'hA5);
    pair;
    chk(sr1_out, 8'hA0);
    cmd(AMR_CMD_EN4B);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(sr1_out, 8'hA0);
    st(1'b0);
  endtask : t_sr1
  task automatic t_xip;
    cmd(AMR_CMD_EN4B);
    xip_active <= 1'b1;
    @(posedge aclk);
    xip_active <= 1'b0;
    pair;
    st(1'b1);
    cmd(AMR_CMD_EXIT_XIP);
    pair;
    st(1'b0);
  endtask : t_xip
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_param;
    t_order;
    t_width;
    t_sr1;
    t_xip;
    summarize;
  end
  // Watchdog, far beyond the few hundred cycles the scenarios need
  initial begin
    #2000000;
    errors++;
    summarize;
  end
endmodule : test_addr_mode_reset_param_table

// >>> src/amr_device.sv
`timescale 1ns/100ps
// Operation
// - B7h enters 4-byte mode, no write-enable
// - Dedicated 4-byte instruction set reported
// - Any reset returns to 3-byte addressing
// - Soft reset only after 66h then 99h
// - Reset pair decoded at current width
// - Host exits quad XIP before reset
// - SR1 mixes volatile and non-volatile bits
// - SR1 write needs prior write enable
// - Dword reads F0 30 F8 A1 upward
// - Following byte reads 6Bh support bits
module amr_device
  import amr_pkg::*;
(
  // Clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Link
  amr_link_if.dev    link,
  // User side
  input  wire logic [1:0] op_width,
  input  wire logic  xip_active,
  output logic [7:0] sr1_out,
  output logic       wren_out
);
  // Decoded strobes, one per instruction
  logic       take;
  logic       width_ok;
  logic       do_en4b;
  logic       do_wren;
  logic       do_rsten;
  logic       do_rst;
  logic       do_wrsr1;
  logic       do_rdparam;
  logic       do_exit_xip;
  logic       soft_rst;
  logic       sr1_write;
  logic [7:0] sr1_rst_val;
  logic       mode4_reg;
  logic       mode4_next;
  logic       rsten_reg;
  logic       rsten_next;
  logic       wel_reg;
  logic       wel_next;
  logic       xip_reg;
  logic       xip_next;
  logic [7:0] sr1_reg;
  logic [7:0] sr1_next;
  logic       ack_reg;
  logic       ack_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  // Non-volatile store: power-up value only, never reset
  logic [7:0] nv_reg = AMR_SR1_NV_INIT;
  logic [7:0] nv_next;

  // -----------------------------
  // Parameter table
  // -----------------------------
  // Fixed bytes; offsets outside the table read as erased
  function automatic logic [7:0] param_byte(input logic [7:0] ofs);
    case (ofs)
      AMR_OFS_DW16_B0: param_byte = AMR_RST_DW16_B0;
      AMR_OFS_DW16_B1: param_byte = AMR_RST_DW16_B1;
      AMR_OFS_DW16_B2: param_byte = AMR_RST_DW16_B2;
      AMR_OFS_DW16_B3: param_byte = AMR_RST_DW16_B3;
      AMR_OFS_4B_SUP:  param_byte = AMR_RST_4B_SUP;
      default:         param_byte = AMR_PARAM_UNMAP;
    endcase
  endfunction : param_byte

  // -----------------------------
  // Decoder
  // -----------------------------
  // The standing ack masks the held request, so each is taken once
  assign take     = link.req && !ack_reg;
  // Width must match the current mode, else the code is dropped
  assign width_ok = (link.width == op_width);

  // Strobes; during continuous read only the exit code is heard
  always_comb begin
    do_en4b     = 1'b0;
    do_wren     = 1'b0;
    do_rsten    = 1'b0;
    do_rst      = 1'b0;
    do_wrsr1    = 1'b0;
    do_rdparam  = 1'b0;
    do_exit_xip = 1'b0;
    if (take && width_ok) begin
      if (xip_reg) begin
        do_exit_xip = (link.opcode == AMR_CMD_EXIT_XIP);
      end else begin
        case (link.opcode)
          AMR_CMD_EN4B:    do_en4b    = 1'b1;
          AMR_CMD_WREN:    do_wren    = 1'b1;
          AMR_CMD_RST_EN:  do_rsten   = 1'b1;
          AMR_CMD_RST:     do_rst     = 1'b1;
          AMR_CMD_WRSR1:   do_wrsr1   = 1'b1;
          AMR_CMD_RDPARAM: do_rdparam = 1'b1;
          default: begin
          end
        endcase
      end
    end
  end

  // Reset acts only when 99h directly follows 66h
  assign soft_rst  = do_rst && rsten_reg;
  // Status write is refused while write enable is clear
  assign sr1_write = do_wrsr1 && wel_reg;

  // -----------------------------
  // Address mode
  // -----------------------------
  // Soft reset ranks above entry; both cannot come in one cycle anyway
  always_comb begin
    mode4_next = mode4_reg;
    if (soft_rst) begin
      mode4_next = 1'b0;
    end else if (do_en4b) begin
      mode4_next = 1'b1;
    end
  end

  // Hardware reset returns to 3-byte addressing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode4_reg <= 1'b0;
    end else begin
      mode4_reg <= mode4_next;
    end
  end

  // -----------------------------
  // Reset enable
  // -----------------------------
  // Any other taken code, even one dropped for width, breaks the pair
  always_comb begin
    rsten_next = rsten_reg;
    if (take) begin
      rsten_next = do_rsten;
    end
  end

  // Armed state is volatile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsten_reg <= 1'b0;
    end else begin
      rsten_reg <= rsten_next;
    end
  end

  // -----------------------------
  // Write enable
  // -----------------------------
  // Used up by an accepted status write; soft reset drops it too
  always_comb begin
    wel_next = wel_reg;
    if (soft_rst || sr1_write) begin
      wel_next = 1'b0;
    end else if (do_wren) begin
      wel_next = 1'b1;
    end
  end

  // Latch clears on hardware reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wel_reg <= 1'b0;
    end else begin
      wel_reg <= wel_next;
    end
  end

  // -----------------------------
  // Continuous read
  // -----------------------------
  // Entry from the read path wins over a same-cycle exit code
  always_comb begin
    xip_next = xip_reg;
    if (do_exit_xip) begin
      xip_next = 1'b0;
    end
    if (xip_active) begin
      xip_next = 1'b1;
    end
  end

  // Hardware reset leaves continuous read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xip_reg <= 1'b0;
    end else begin
      xip_reg <= xip_next;
    end
  end

  // -----------------------------
  // Status register 1
  // -----------------------------
  // Volatile bits come back at their reset value, stored bits survive
  assign sr1_rst_val = (nv_reg & AMR_SR1_NV_MASK) | (AMR_SR1_RST & ~AMR_SR1_NV_MASK);

  // An accepted write updates both copies of the stored bits
  always_comb begin
    sr1_next = sr1_reg;
    nv_next  = nv_reg;
    if (sr1_write) begin
      sr1_next = link.arg;
      nv_next  = link.arg & AMR_SR1_NV_MASK;
    end else if (soft_rst) begin
      sr1_next = sr1_rst_val;
    end
  end

  // Visible register reloads from the store during hardware reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr1_reg <= sr1_rst_val;
    end else begin
      sr1_reg <= sr1_next;
    end
  end

  // Store has no reset: it models cells that keep their value
  always_ff @(posedge aclk) begin
    nv_reg <= nv_next;
  end

  // -----------------------------
  // Answer
  // -----------------------------
  // Ack stands one cycle; read data stands until the next read
  always_comb begin
    ack_next   = take;
    rdata_next = rdata_reg;
    if (do_rdparam) begin
      rdata_next = param_byte(link.arg);
    end
  end

  // Answer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign link.ack     = ack_reg;
  assign link.rdata   = rdata_reg;
  assign link.mode_4b = mode4_reg;
  assign sr1_out      = sr1_reg;
  assign wren_out     = wel_reg;
endmodule : amr_device

// >>> src/amr_host.sv
`timescale 1ns/100ps
module amr_host
  import amr_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link
  amr_link_if.host         link
);
  typedef enum {AMR_IDLE, AMR_REQ, AMR_WAIT} amr_st_t;
  amr_st_t     st_reg,    st_next;
  logic [15:0] cmd_reg,   cmd_next;
  logic [1:0]  width_reg, width_next;
  logic [31:0] dw_reg,    dw_next;
  logic [1:0]  bidx_reg,  bidx_next;
  logic        dwmode_reg, dwmode_next;
  logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [3:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;

  // -----------------------------
  // Register bus and sequencer
  // -----------------------------
  // CMD write: [7:0] opcode, [15:8] arg; CTRL: [1:0] width, [2] dword read
  always_comb begin
    st_next = st_reg; cmd_next = cmd_reg; width_next = width_reg; dw_next = dw_reg;
    bidx_next = bidx_reg; dwmode_next = dwmode_reg;
    aw_next = aw_reg; w_next = w_reg; bv_next = bv_reg; rv_next = rv_reg;
    awa_next = awa_reg; wd_next = wd_reg; rd_next = rd_reg; br_next = br_reg; rr_next = rr_reg;
    if (s_axi_awvalid && !aw_reg && !bv_reg) begin
      aw_next = 1'b1; awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg && !bv_reg) begin
      w_next = 1'b1; wd_next = s_axi_wdata;
    end
    if (aw_reg && w_reg && !bv_reg) begin
      bv_next = 1'b1; br_next = AMR_RESP_OKAY;
      case (awa_reg)
        AMR_REG_CMD: begin
          if (st_reg == AMR_IDLE) begin
            cmd_next = wd_reg[15:0]; st_next = AMR_REQ; bidx_next = 2'h0;
            // Dword read walks four rising offsets
            if (dwmode_reg) dw_next = 32'h0;
          end else br_next = AMR_RESP_SLVERR;
        end
        AMR_REG_CTRL: begin
          width_next = wd_reg[1:0]; dwmode_next = wd_reg[2];
        end
        default: br_next = AMR_RESP_SLVERR;
      endcase
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0; aw_next = 1'b0; w_next = 1'b0;
    end
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1; rr_next = AMR_RESP_OKAY;
      case (s_axi_araddr)
        AMR_REG_CMD:   rd_next = {16'h0, cmd_reg};
        AMR_REG_CTRL:  rd_next = {29'h0, dwmode_reg, width_reg};
        AMR_REG_STAT:  rd_next = {30'h0, link.mode_4b, st_reg != AMR_IDLE};
        AMR_REG_RDATA: rd_next = dw_reg;
        default: begin rd_next = 32'h0; rr_next = AMR_RESP_SLVERR; end
      endcase
    end else if (rv_reg && s_axi_rready) rv_next = 1'b0;
    case (st_reg)
      AMR_IDLE: ;
      AMR_REQ:  if (link.ack) st_next = AMR_WAIT;
      AMR_WAIT: begin
        dw_next = dw_reg;
        dw_next[8*bidx_reg +: 8] = link.rdata;
        if (dwmode_reg && bidx_reg != 2'h3) begin
          bidx_next = bidx_reg + 2'h1;
          cmd_next  = {cmd_reg[15:8] + 8'h01, cmd_reg[7:0]};
          st_next   = AMR_REQ;
        end else st_next = AMR_IDLE;
      end
      default: st_next = AMR_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= AMR_IDLE; cmd_reg <= 16'h0; width_reg <= AMR_W1; dw_reg <= 32'h0;
      bidx_reg <= 2'h0; dwmode_reg <= 1'b0; aw_reg <= 1'b0; w_reg <= 1'b0;
      bv_reg <= 1'b0; rv_reg <= 1'b0; awa_reg <= 4'h0; wd_reg <= 32'h0;
      rd_reg <= 32'h0; br_reg <= 2'h0; rr_reg <= 2'h0;
    end else begin
      st_reg <= st_next; cmd_reg <= cmd_next; width_reg <= width_next; dw_reg <= dw_next;
      bidx_reg <= bidx_next; dwmode_reg <= dwmode_next; aw_reg <= aw_next; w_reg <= w_next;
      bv_reg <= bv_next; rv_reg <= rv_next; awa_reg <= awa_next; wd_reg <= wd_next;
      rd_reg <= rd_next; br_reg <= br_next; rr_reg <= rr_next;
    end
  end

  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready  = !w_reg && !bv_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  // Soft reset ordering (66h then 99h) and XIP exit are software's order of CMD writes
  assign link.req    = (st_reg == AMR_REQ);
  assign link.opcode = cmd_reg[7:0];
  assign link.arg    = cmd_reg[15:8];
  assign link.width  = width_reg;
endmodule : amr_host

// >>> src/amr_link_if.sv
`timescale 1ns/100ps
// One instruction transaction: host offers an opcode with argument, device answers
interface amr_link_if;
  logic       req;
  logic [7:0] opcode;
  logic [7:0] arg;
  logic [1:0] width;
  logic       ack;
  logic [7:0] rdata;
  logic       mode_4b;
  modport dev  (input req, opcode, arg, width, output ack, rdata, mode_4b);
  modport host (output req, opcode, arg, width, input ack, rdata, mode_4b);
endinterface : amr_link_if

// >>> src/amr_pkg.sv
package amr_pkg;
  // Instruction codes
  localparam logic [7:0] AMR_CMD_WREN      = 8'h06;
  localparam logic [7:0] AMR_CMD_EN4B      = 8'hB7;
  localparam logic [7:0] AMR_CMD_RST_EN    = 8'h66;
  localparam logic [7:0] AMR_CMD_RST       = 8'h99;
  localparam logic [7:0] AMR_CMD_WRSR1     = 8'h01;
  localparam logic [7:0] AMR_CMD_RDPARAM   = 8'h5A;
  localparam logic [7:0] AMR_CMD_EXIT_XIP  = 8'hFF;
  // Parameter table offsets and contents
  localparam logic [7:0] AMR_OFS_DW16_B0   = 8'h3C;
  localparam logic [7:0] AMR_OFS_DW16_B1   = 8'h3D;
  localparam logic [7:0] AMR_OFS_DW16_B2   = 8'h3E;
  localparam logic [7:0] AMR_OFS_DW16_B3   = 8'h3F;
  localparam logic [7:0] AMR_OFS_4B_SUP    = 8'h40;
  localparam logic [7:0] AMR_RST_DW16_B0   = 8'hF0;
  localparam logic [7:0] AMR_RST_DW16_B1   = 8'h30;
  localparam logic [7:0] AMR_RST_DW16_B2   = 8'hF8;
  localparam logic [7:0] AMR_RST_DW16_B3   = 8'hA1;
  localparam logic [7:0] AMR_RST_4B_SUP    = 8'h6B;
  localparam logic [7:0] AMR_PARAM_UNMAP   = 8'hFF;
  // Dword field positions
  localparam int         AMR_ENTER_LSB     = 24;
  localparam int         AMR_DEDIC4B_BIT   = 29;
  // Status register 1: bits 7:4 non-volatile, 3:0 volatile
  localparam logic [7:0] AMR_SR1_NV_MASK   = 8'hF0;
  localparam logic [7:0] AMR_SR1_RST       = 8'h00;
  localparam logic [7:0] AMR_SR1_NV_INIT   = 8'h00;
  // Line width codes
  localparam logic [1:0] AMR_W1            = 2'h0;
  localparam logic [1:0] AMR_W2            = 2'h1;
  localparam logic [1:0] AMR_W4            = 2'h2;
  // Controller registers (AXI4-Lite byte addresses)
  localparam logic [3:0] AMR_REG_CMD       = 4'h0;
  localparam logic [3:0] AMR_REG_CTRL      = 4'h4;
  localparam logic [3:0] AMR_REG_STAT      = 4'h8;
  localparam logic [3:0] AMR_REG_RDATA     = 4'hC;
  localparam logic [1:0] AMR_RESP_OKAY     = 2'h0;
  localparam logic [1:0] AMR_RESP_SLVERR   = 2'h2;
endpackage : amr_pkg
